//--- design/ocs_map.vh
`ifndef OCS_MAP_VH
`define OCS_MAP_VH

// Register indices on the plain port
`define OCS_ADDR_W          4
`define OCS_A_PATH          4'h0
`define OCS_A_FRAME_SYNC_OUT         4'h1
`define OCS_A_TELECOM       4'h2
`define OCS_A_SECAPLL       4'h3
`define OCS_A_FORMAT        4'h4
`define OCS_A_INC_MAIN      4'h5
`define OCS_A_INC_SEC       4'h6
`define OCS_A_STATUS        4'h7
`define OCS_A_OFFSET        4'h8

// Path cfg fields
`define OCS_B_LOCK          0
`define OCS_B_FRAMESYNC_INDEPENDENT_MODE         1
`define OCS_B_LR_SRC        2
`define OCS_B_T1_SRC        3
`define OCS_B_T2_SRC        4
`define OCS_B_APLL_MAIN     5
// Frame sync cfg fields
`define OCS_F_FS_POL        0
`define OCS_F_MF_POL        1
`define OCS_F_FS_W_LO       2
`define OCS_F_FS_W_HI       9
`define OCS_F_MF_W_LO       10
`define OCS_F_MF_W_HI       17
// Telecom cfg fields
`define OCS_T_T1_F_LO       0
`define OCS_T_T1_F_HI       1
`define OCS_T_T1_SS         2
`define OCS_T_T2_F_LO       3
`define OCS_T_T2_F_HI       4
`define OCS_T_T2_SS         5
`define OCS_T_T2_AF         6

// Output format codes
`define OCS_FMT_OFF         2'h0
`define OCS_FMT_LVDS        2'h1
`define OCS_FMT_PECL        2'h2

// Accumulator
`define OCS_ACC_W           32
`define OCS_PH_W            4
// 204.8 MHz master clock in kHz
`define OCS_MCLK_KHZ        204800
`define OCS_FS_KHZ          8
`define OCS_MFS_DIV         4
`define OCS_RST_ZERO        32'h0000_0000
`define OCS_SYNC_DEPTH      2

`endif

//--- design/ocs_core.v
// Operation
// - Frame sync 8 kHz, multiframe 2 kHz
// - Programmable sync pulse width and polarity
// - Per differential output format or disable
// - Synths add increment into phase accumulator
// - Accumulator phase code exposed for edges
// - Secondary one forward, main forward plus feedback
// - Main feedback carries phase offset
// - Feedback synth fed by own path
// - Seven output synths, two main-fixed
// - Global lock forces all to main
// - Frame sync main unless independent mode
// - Low-rate synth follows its source bit
// - Each telecom synth own source bit
// - Telecom one: standard and two-bit field
// - Telecom two: alt, standard, two-bit field
// - Each APLL from own reference synth
// - Main APLL references always main path
// - Secondary APLL ref by to-main bit
// - Freq zero and not-to-main powers down
// - Powered-down APLL outputs held low
// - To-main bit locks secondary APLL
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ocs_map.vh"

module ocs_core (
	input  wire                    clk,
	input  wire                    rstn,
	input  wire [`OCS_ADDR_W-1:0]  addr,
	input  wire [31:0]             wdata,
	input  wire                    wr_en,
	input  wire                    rd_en,
	output reg  [31:0]             rdata,
	output reg                     frame_sync_out,
	output reg                     multiframe_sync_out,
	output reg  [6:0]              config_output_clocks,
	output reg  [3:0]              diff_out_en,
	output reg  [7:0]              diff_out_pecl,
	output reg  [27:0]             synth_phase_code,
	output reg  [1:0]              feedback_clk,
	output wire                    sec_apll_powered
);

	reg [31:0] global_path_cfg_reg;
	reg [31:0] framesync_cfg_reg;
	reg [31:0] telecom_freq_cfg_reg;
	reg [31:0] sec_path_cfg_reg;
	reg [31:0] output_format_cfg_reg;
	reg [31:0] inc_main_reg;
	reg [31:0] inc_sec_reg;
	reg [31:0] offset_reg;
	reg [6:0]  src_main_vec;

	// Map selection and path to effective source: 1 = main
	function sel_main;
		input lock;
		input src_main;
		begin
			sel_main = lock | src_main;
		end
	endfunction

	// Telecom frequency code to fraction of selected path increment (shift)
	function [2:0] tel_shift;
		input [1:0] f;
		begin
			tel_shift = 3'h3 - {1'b0, f};
		end
	endfunction

	wire lock_secondary_to_main = global_path_cfg_reg[`OCS_B_LOCK];
	wire framesync_independent_mode = global_path_cfg_reg[`OCS_B_FRAMESYNC_INDEPENDENT_MODE];
	wire lowrate_synth_src_sel = global_path_cfg_reg[`OCS_B_LR_SRC];
	wire telecom1_src_sel = global_path_cfg_reg[`OCS_B_T1_SRC];
	wire telecom2_src_sel = global_path_cfg_reg[`OCS_B_T2_SRC];
	wire sec_apll_to_main = global_path_cfg_reg[`OCS_B_APLL_MAIN];
	wire [3:0] sec_apll_freq_field = sec_path_cfg_reg[3:0];
	wire [1:0] telecom1_freq_field =
		telecom_freq_cfg_reg[`OCS_T_T1_F_HI:`OCS_T_T1_F_LO];
	wire telecom1_std_sel = telecom_freq_cfg_reg[`OCS_T_T1_SS];
	wire [1:0] telecom2_freq_field =
		telecom_freq_cfg_reg[`OCS_T_T2_F_HI:`OCS_T_T2_F_LO];
	wire telecom2_std_sel = telecom_freq_cfg_reg[`OCS_T_T2_SS];
	wire telecom2_alt_freq = telecom_freq_cfg_reg[`OCS_T_T2_AF];

	// Register port; writes and reads never stall
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			global_path_cfg_reg <= `OCS_RST_ZERO;
			framesync_cfg_reg <= `OCS_RST_ZERO;
			telecom_freq_cfg_reg <= `OCS_RST_ZERO;
			sec_path_cfg_reg <= `OCS_RST_ZERO;
			output_format_cfg_reg <= `OCS_RST_ZERO;
			inc_main_reg <= `OCS_RST_ZERO;
			inc_sec_reg <= `OCS_RST_ZERO;
			offset_reg <= `OCS_RST_ZERO;
			rdata <= `OCS_RST_ZERO;
		end else begin
			if (wr_en) begin
				case (addr)
				`OCS_A_PATH:     global_path_cfg_reg <= wdata;
				`OCS_A_FRAME_SYNC_OUT:    framesync_cfg_reg <= wdata;
				`OCS_A_TELECOM:  telecom_freq_cfg_reg <= wdata;
				`OCS_A_SECAPLL:  sec_path_cfg_reg <= wdata;
				`OCS_A_FORMAT:   output_format_cfg_reg <= wdata;
				`OCS_A_INC_MAIN: inc_main_reg <= wdata;
				`OCS_A_INC_SEC:  inc_sec_reg <= wdata;
				`OCS_A_OFFSET:   offset_reg <= wdata;
				default: ;
				endcase
			end
			rdata <= `OCS_RST_ZERO;
			if (rd_en) begin
				case (addr)
				`OCS_A_PATH:     rdata <= global_path_cfg_reg;
				`OCS_A_FRAME_SYNC_OUT:    rdata <= framesync_cfg_reg;
				`OCS_A_TELECOM:  rdata <= telecom_freq_cfg_reg;
				`OCS_A_SECAPLL:  rdata <= sec_path_cfg_reg;
				`OCS_A_FORMAT:   rdata <= output_format_cfg_reg;
				`OCS_A_INC_MAIN: rdata <= inc_main_reg;
				`OCS_A_INC_SEC:  rdata <= inc_sec_reg;
				`OCS_A_OFFSET:   rdata <= offset_reg;
				`OCS_A_STATUS:   rdata <= {24'h0, sec_apll_powered,
					src_main_vec};
				default:         rdata <= `OCS_RST_ZERO;
				endcase
			end
		end
	end

	// Sources of the seven output synths: 1 = main path
	// 0 lowrate, 1 tel1, 2 tel2, 3 sec apll ref, 4 frame sync,
	// 5 main apll ref, 6 second main apll ref
	always @* begin
		src_main_vec[0] = sel_main(lock_secondary_to_main,
			~lowrate_synth_src_sel);
		src_main_vec[1] = sel_main(lock_secondary_to_main,
			~telecom1_src_sel);
		src_main_vec[2] = sel_main(lock_secondary_to_main,
			~telecom2_src_sel);
		src_main_vec[3] = sel_main(lock_secondary_to_main,
			sec_apll_to_main);
		src_main_vec[4] = sel_main(lock_secondary_to_main,
			~framesync_independent_mode);
		src_main_vec[5] = 1'b1;
		src_main_vec[6] = 1'b1;
	end

	// Secondary APLL power state
	assign sec_apll_powered = ~((sec_apll_freq_field == 4'h0) &
		~sec_apll_to_main);

	// Path forward synths; main has separate output and feedback
	reg [`OCS_ACC_W-1:0] main_fwd_acc;
	reg [`OCS_ACC_W-1:0] main_fb_acc;
	reg [`OCS_ACC_W-1:0] sec_fwd_acc;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			main_fwd_acc <= `OCS_RST_ZERO;
			main_fb_acc <= `OCS_RST_ZERO;
			sec_fwd_acc <= `OCS_RST_ZERO;
			feedback_clk <= 2'h0;
		end else begin
			main_fwd_acc <= main_fwd_acc + inc_main_reg;
			// Feedback follows own forward synth plus offset
			main_fb_acc <= main_fwd_acc + offset_reg;
			sec_fwd_acc <= sec_fwd_acc + inc_sec_reg;
			feedback_clk[0] <= main_fb_acc[`OCS_ACC_W-1];
			feedback_clk[1] <= sec_fwd_acc[`OCS_ACC_W-1];
		end
	end

	// Per synth increments derived from selected path
	reg [`OCS_ACC_W-1:0] inc_vec [0:6];
	always @* begin
		inc_vec[0] = src_main_vec[0] ? inc_main_reg : inc_sec_reg;
		inc_vec[1] = (src_main_vec[1] ? inc_main_reg : inc_sec_reg)
			>> (tel_shift(telecom1_freq_field) +
			{2'h0, telecom1_std_sel});
		inc_vec[2] = (src_main_vec[2] ? inc_main_reg : inc_sec_reg)
			>> (tel_shift(telecom2_freq_field) +
			{1'b0, telecom2_std_sel, telecom2_alt_freq});
		inc_vec[3] = src_main_vec[3] ? inc_main_reg : inc_sec_reg;
		inc_vec[4] = src_main_vec[4] ? inc_main_reg : inc_sec_reg;
		inc_vec[5] = inc_main_reg;
		inc_vec[6] = inc_main_reg;
	end

	// Increments latched at accumulator wrap to avoid runts, or while the live increment is zero
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1) begin : gen_synth
			reg [`OCS_ACC_W-1:0] acc;
			reg [`OCS_ACC_W-1:0] inc_live;
			wire [`OCS_ACC_W:0] sum = {1'b0, acc} + {1'b0, inc_live};
			always @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					acc <= `OCS_RST_ZERO;
					inc_live <= `OCS_RST_ZERO;
					config_output_clocks[g] <= 1'b0;
					synth_phase_code[g*`OCS_PH_W +: `OCS_PH_W] <= 4'h0;
				end else begin
					acc <= sum[`OCS_ACC_W-1:0];
					if (sum[`OCS_ACC_W] || inc_live == `OCS_RST_ZERO)
						inc_live <= inc_vec[g];
					synth_phase_code[g*`OCS_PH_W +: `OCS_PH_W] <=
						acc[`OCS_ACC_W-1 -: `OCS_PH_W];
					if (g == 3 && !sec_apll_powered)
						config_output_clocks[g] <= 1'b0;
					else
						config_output_clocks[g] <= acc[`OCS_ACC_W-1];
				end
			end
		end
	endgenerate

	// Frame sync from synth 4: 8 kHz tick, multiframe every fourth
	localparam [`OCS_ACC_W-1:0] FS_INC_DEFAULT = 32'h0000_0000;
	wire fs_msb = gen_synth[4].acc[`OCS_ACC_W-1];
	reg        fs_msb_d;
	reg [1:0]  mf_cnt;
	reg [7:0]  fs_w_cnt;
	reg [7:0]  mf_w_cnt;
	wire       fs_tick = fs_msb & ~fs_msb_d;
	wire [7:0] fs_width = framesync_cfg_reg[`OCS_F_FS_W_HI:`OCS_F_FS_W_LO];
	wire [7:0] mf_width = framesync_cfg_reg[`OCS_F_MF_W_HI:`OCS_F_MF_W_LO];
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fs_msb_d <= 1'b0;
			mf_cnt <= 2'h0;
			fs_w_cnt <= 8'h0;
			mf_w_cnt <= 8'h0;
			frame_sync_out <= 1'b0;
			multiframe_sync_out <= 1'b0;
		end else begin
			fs_msb_d <= fs_msb;
			if (fs_tick) begin
				mf_cnt <= mf_cnt + 2'h1;
				fs_w_cnt <= fs_width;
				if (mf_cnt == 2'h0)
					mf_w_cnt <= mf_width;
			end else begin
				if (fs_w_cnt != 8'h0)
					fs_w_cnt <= fs_w_cnt - 8'h1;
				if (mf_w_cnt != 8'h0)
					mf_w_cnt <= mf_w_cnt - 8'h1;
			end
			frame_sync_out <= (fs_w_cnt != 8'h0) ^
				framesync_cfg_reg[`OCS_F_FS_POL];
			multiframe_sync_out <= (mf_w_cnt != 8'h0) ^
				framesync_cfg_reg[`OCS_F_MF_POL];
		end
	end

	// Differential output format per output 3..6
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_fmt
			wire [1:0] fmt = output_format_cfg_reg[2*g +: 2];
			always @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					diff_out_en[g] <= 1'b0;
					diff_out_pecl[2*g +: 2] <= 2'h0;
				end else begin
					diff_out_en[g] <= (fmt != `OCS_FMT_OFF);
					diff_out_pecl[2*g +: 2] <= fmt;
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

//--- tb/ocs_core_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ocs_chk (
	input wire logic	clk,
	input wire logic	rstn,
	input wire logic [3:0]	addr,
	input wire logic [31:0]	wdata,
	input wire logic	wr_en,
	input wire logic	rd_en,
	input wire logic [31:0]	rdata,
	input wire logic [6:0]	config_output_clocks,
	input wire logic [3:0]	diff_out_en,
	input wire logic [7:0]	diff_out_pecl,
	input wire logic	sec_apll_powered
);
	logic [5:0]	path_reg;
	logic [3:0]	secf_reg;
	logic	st_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Shadow of the written config, so status reads can be judged
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			path_reg <= 6'h00;
			secf_reg <= 4'h0;
			st_reg <= 1'b0;
		end else begin
			st_reg <= rd_en && addr == 4'h7;
			if (wr_en && addr == 4'h0)
				path_reg <= wdata[5:0];
			if (wr_en && addr == 4'h3)
				secf_reg <= wdata[3:0];
		end
	end
	AST_FMT_EN: assert property (diff_out_en == {|diff_out_pecl[7:6],
		|diff_out_pecl[5:4], |diff_out_pecl[3:2], |diff_out_pecl[1:0]})
		else $error("diff enable disagrees with format");
	AST_SEC_LOW: assert property (!sec_apll_powered [*2]
		|-> !config_output_clocks[3]) else $error("sec ref not low");
	AST_MAIN_FIXED: assert property (st_reg |-> rdata[6:5] == 2'h3)
		else $error("main APLL refs not on main");
	AST_LOCK_ALL: assert property (st_reg && path_reg[0]
		|-> rdata[6:0] == 7'h7f) else $error("lock did not force main");
	AST_FS_SRC: assert property (st_reg && !path_reg[0]
		|-> rdata[4] == !path_reg[1]) else $error("frame sync source wrong");
	AST_SEL_SRC: assert property (st_reg && !path_reg[0]
		|-> rdata[3:0] == {path_reg[5], ~path_reg[4:2]})
		else $error("selectable source wrong");
	AST_PWR: assert property (sec_apll_powered ==
		(|secf_reg || path_reg[5])) else $error("power state wrong");
	AST_ST_PWR: assert property (st_reg |-> rdata[7] == $past(sec_apll_powered))
		else $error("status power bit wrong");
endmodule
bind ocs_core ocs_chk u_chk (.clk(clk), .rstn(rstn), .addr(addr),
	.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
	.config_output_clocks(config_output_clocks), .diff_out_en(diff_out_en),
	.diff_out_pecl(diff_out_pecl), .sec_apll_powered(sec_apll_powered));
`default_nettype wire

//--- tb/ocs_pulse_rx.sv
`timescale 1ns/1ns
`default_nettype none
module ocs_pulse_rx (
	input wire logic	clk,
	input wire logic	rstn,
	input wire logic	line,
	input wire logic	pol,
	output logic [15:0]	cnt,
	output logic [15:0]	width
);
	logic [15:0]	run;
	// Long runs are idle time, not pulses; a run open since reset
	// saturates so a later polarity change is not taken as a pulse
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run <= 16'hffff;
			cnt <= 16'h0;
			width <= 16'h0;
		end else if (line != pol) begin
			if (run != 16'hffff)
				run <= run + 16'h1;
		end else begin
			if (run != 16'h0 && run < 16'h100) begin
				cnt <= cnt + 16'h1;
				width <= run;
			end
			run <= 16'h0;
		end
	end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ocs_map.vh"
module tb;
	typedef struct {logic [5:0] p; logic [3:0] f; logic [7:0] st;} ocs_row_t;
	ocs_row_t	rows[6] = '{'{6'h00, 4'h0, 8'h77}, '{6'h1e, 4'h0, 8'h60},
		'{6'h1f, 4'h0, 8'h7f}, '{6'h20, 4'h0, 8'hff},
		'{6'h14, 4'h5, 8'hf2}, '{6'h0a, 4'hf, 8'he5}};
	logic	clk = 1'b0;
	logic	rstn = 1'b0;
	logic [3:0]	addr = 4'h0;
	logic [31:0]	wdata = 32'h0;
	logic	wr_en = 1'b0;
	logic	rd_en = 1'b0;
	logic [31:0]	d;
	wire [31:0]	rdata;
	wire	fs, mf, pw;
	wire [6:0]	oc;
	wire [3:0]	den;
	wire [7:0]	dfmt;
	wire [27:0]	ph;
	wire [1:0]	fb;
	wire [15:0]	fs_cnt, fs_w, mf_cnt, mf_w;
	int	n_errors = 0;
	int	checks = 0;
	int	cyc = 0;
	ocs_core DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .frame_sync_out(fs),
		.multiframe_sync_out(mf), .config_output_clocks(oc),
		.diff_out_en(den), .diff_out_pecl(dfmt), .synth_phase_code(ph),
		.feedback_clk(fb), .sec_apll_powered(pw));
	ocs_pulse_rx rx_fs (.clk(clk), .rstn(rstn), .line(fs), .pol(1'b0),
		.cnt(fs_cnt), .width(fs_w));
	ocs_pulse_rx rx_mf (.clk(clk), .rstn(rstn), .line(mf), .pol(1'b1),
		.cnt(mf_cnt), .width(mf_w));
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 99000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#1 chk("reset outs", {fs, mf, oc, den, dfmt, fb, pw}, 32'h0);
		chk("reset rdata", rdata, 32'h0);
		@(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			wr(`OCS_A_PATH, {26'h0, rows[i].p});
			wr(`OCS_A_SECAPLL, {28'h0, rows[i].f});
			repeat (4) @(posedge clk);
			rd(`OCS_A_STATUS);
			chk("status", d[7:0], rows[i].st);
			chk("powered", pw, rows[i].st[7]);
			$display("row %0d done", i);
		end
		wr(4'hf, 32'hffff_ffff);
		rd(4'hf);
		chk("unmapped", d, 32'h0);
		wr(`OCS_A_FORMAT, 32'h24);
		repeat (4) @(posedge clk);
		chk("fmt en", den, 4'h6);
		chk("fmt", dfmt, 8'h24);
		$display("bus and format done");
		// Sync outputs need frame sync on main
		wr(`OCS_A_PATH, 32'h0);
		wr(`OCS_A_INC_MAIN, 32'h0004_31be);
		wr(`OCS_A_FRAME_SYNC_OUT, 32'h2416);
		while (mf_cnt == 16'h0)
			@(posedge clk);
		chk("fs width", fs_w, 16'h5);
		chk("mf width", mf_w, 16'h9);
		chk("fs pulses", fs_cnt != 16'h0, 1'b1);
		$display("sync done");
		wrap_up();
	end
endmodule
`default_nettype wire
